// File: hw/irqf_pkg.sv
package irqf_pkg;

	// Register byte addresses on the register port
	localparam logic [7:0] IRQF_PRIMARY_OFS   = 8'h06;
	localparam logic [7:0] IRQF_SECONDARY_OFS = 8'h07;

	// Values after reset
	localparam logic [6:0] IRQF_PRIMARY_RST   = 7'h00;
	localparam logic [5:0] IRQF_SECONDARY_RST = 6'h00;
	localparam logic [7:0] IRQF_RDATA_RST     = 8'h00;

	// Write-only set/clear selector position, both registers
	localparam int IRQF_SET_POS = 7;

	// Flag positions in event_flags_primary
	localparam int IRQF_UPPER_POS  = 6;
	localparam int IRQF_LOWER_POS  = 5;
	localparam int IRQF_CMDEND_POS = 4;
	localparam int IRQF_TXDONE_POS = 3;
	localparam int IRQF_RXDONE_POS = 2;
	localparam int IRQF_FAULT_POS  = 1;
	localparam int IRQF_FSTART_POS = 0;

	// Flag positions in event_flags_secondary
	localparam int IRQF_GLOBAL_POS = 6;
	localparam int IRQF_CARD_POS   = 5;
	localparam int IRQF_COUNTERS   = 5;

	// Fault inputs: illegal write, overflow, framing, payload, integrity
	localparam int IRQF_FAULTS = 5;

	// Buffer capacity by capacity select (1: small, 0: large)
	localparam logic [9:0] IRQF_CAP_SMALL = 10'h0ff;
	localparam logic [9:0] IRQF_CAP_LARGE = 10'h200;

	// Command field
	localparam int         IRQF_CMD_W    = 4;
	localparam logic [3:0] IRQF_CMD_IDLE = 4'h0;

endpackage

// File: hw/irqf_evt_if.sv
`timescale 1ns/1ps
// Event lines from the helper modules into the flag registers
interface irqf_evt_if;
	logic upper_fill_status;  // Buffer nearly full level
	logic lower_fill_status;  // Buffer nearly empty level
	logic command_end_event;  // One-cycle command end pulse

	modport fill (output upper_fill_status, output lower_fill_status);
	modport cmd  (output command_end_event);
	modport core (input upper_fill_status, input lower_fill_status,
		input command_end_event);
endinterface

// File: hw/irqf_fill_level.sv
`timescale 1ns/1ps
// Fill level comparators, registered once
module irqf_fill_level
	import irqf_pkg::*;
(
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       reset_i,
	// Buffer state
	input  wire logic [9:0] stored_byte_count_i,
	input  wire logic       buffer_capacity_select_i,
	input  wire logic [8:0] water_level_i,
	// Status out
	irqf_evt_if.fill        evt
);

	typedef struct packed {
		logic upper;
		logic lower;
	} irqf_fill_type;

	irqf_fill_type state_reg;  // Registered levels
	irqf_fill_type state_next; // Next levels
	logic [10:0]   room;       // Free space, signed guard bit
	logic [9:0]    cap;        // Active capacity
	logic [9:0]    level;      // Threshold, masked by mode

	// Compare free space and fill against the threshold
	always_comb
	begin
		cap   = buffer_capacity_select_i ? IRQF_CAP_SMALL : IRQF_CAP_LARGE;
		// Threshold top bit only counts in large mode
		level = buffer_capacity_select_i ? {2'h0, water_level_i[7:0]}
			: {1'h0, water_level_i};
		room  = {1'h0, cap} - {1'h0, stored_byte_count_i};
		// Overfilled count gives negative room: still nearly full
		state_next.upper = room[10] || (room[9:0] <= level); // RL7
		state_next.lower = stored_byte_count_i <= level;     // RL8
	end

	// State register
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			state_reg <= '0;
		else
			state_reg <= state_next;
	end

	assign evt.upper_fill_status = state_reg.upper;
	assign evt.lower_fill_status = state_reg.lower;

endmodule

// File: hw/irqf_cmd_watch.sv
`timescale 1ns/1ps
// Command field tracker and command end detector
module irqf_cmd_watch
	import irqf_pkg::*;
#(
	parameter logic [15:0] KNOWN_CMD_MASK = 16'h00ff // Legal codes
)
(
	// Clock and reset
	input  wire logic                  clk_i,
	input  wire logic                  reset_i,
	// Command control
	input  wire logic                  cmd_start_i,
	input  wire logic [IRQF_CMD_W-1:0] cmd_code_i,
	input  wire logic                  cmd_done_i,
	output logic [IRQF_CMD_W-1:0]      cmd_field_o,
	// Event out
	irqf_evt_if.cmd                    evt
);

	typedef enum logic [0:0] {
		IRQF_ST_IDLE = 1'b0,
		IRQF_ST_BUSY = 1'b1
	} irqf_cmd_st_type;

	typedef struct packed {
		irqf_cmd_st_type        st;
		logic [IRQF_CMD_W-1:0]  field;
		logic                   end_pulse;
	} irqf_cmd_type;

	irqf_cmd_type s_reg;  // Registered state
	irqf_cmd_type s_next; // Next state

	// Start takes priority over done: a restart wins
	always_comb
	begin
		s_next           = s_reg;
		s_next.end_pulse = 1'b0;
		if (cmd_start_i)
		begin
			if (cmd_code_i == IRQF_CMD_IDLE)
			begin
				// Host-started idle: silent stop
				s_next.st    = IRQF_ST_IDLE; // RL11
				s_next.field = IRQF_CMD_IDLE;
			end
			else if (!KNOWN_CMD_MASK[cmd_code_i])
			begin
				// Unknown code falls straight back to idle
				s_next.st        = IRQF_ST_IDLE; // RL10
				s_next.field     = IRQF_CMD_IDLE;
				s_next.end_pulse = 1'b1;
			end
			else
			begin
				s_next.st    = IRQF_ST_BUSY;
				s_next.field = cmd_code_i;
			end
		end
		else
		begin
			unique case (s_reg.st)
				IRQF_ST_IDLE: s_next.st = IRQF_ST_IDLE;
				IRQF_ST_BUSY:
				begin
					if (cmd_done_i)
					begin
						// Command ended on its own
						s_next.st        = IRQF_ST_IDLE; // RL9
						s_next.field     = IRQF_CMD_IDLE;
						s_next.end_pulse = 1'b1;
					end
				end
			endcase
		end
	end

	// State register
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
			s_reg <= '{IRQF_ST_IDLE, IRQF_CMD_IDLE, 1'b0};
		else
			s_reg <= s_next;
	end

	assign cmd_field_o           = s_reg.field;
	assign evt.command_end_event = s_reg.end_pulse;

endmodule

// File: hw/irqf_top.sv
`timescale 1ns/1ps
// Summary of operation
// RL1: Primary write, selector high: ones set flags
// RL2: Primary write, selector low: ones clear flags
// RL3: Zero bits written leave flags untouched
// RL4: Secondary selector acts on bits 5..0
// RL5: Upper fill status latches bit 6
// RL6: Lower fill status latches bit 5
// RL7: Upper status: free space at most threshold
// RL8: Lower status: fill at most threshold
// RL9: Self-ended command sets command end flag
// RL10: Unknown command returns idle, sets flag
// RL11: Host-started idle sets no flag
// RL12: Last transmitted bit sets bit 3
// RL13: Receive stream end sets bit 2
// RL14: Host checks faults after receive done
// RL15: Any of five faults sets bit 1
// RL16: Frame start sets bit 0
// RL17: Global bit 6 follows enabled flags
// RL18: Only enabled flags feed global request
// RL19: Card presence sets secondary bit 5
// RL20: Counter underflows set bits 4..0
// RL21: Primary register resets to zero
// RL22: Selector bit not stored, reads zero
// RL23: Event beats clear in same cycle
module irqf_top
	import irqf_pkg::*;
#(
	parameter logic [15:0] KNOWN_CMD_MASK = 16'h00ff // Legal codes
)
(
	// Clock and reset
	input  wire logic                     clk_i,
	input  wire logic                     reset_i,
	// Register port
	input  wire logic [7:0]               reg_addr_i,
	input  wire logic                     reg_wr_i,
	input  wire logic                     reg_rd_i,
	input  wire logic [7:0]               reg_wdata_i,
	output logic [7:0]                    reg_rdata_o,
	// Buffer state
	input  wire logic [9:0]               stored_byte_count_i,
	input  wire logic                     buffer_capacity_select_i,
	input  wire logic [8:0]               water_level_i,
	// Command control
	input  wire logic                     cmd_start_i,
	input  wire logic [IRQF_CMD_W-1:0]    cmd_code_i,
	input  wire logic                     cmd_done_i,
	output logic [IRQF_CMD_W-1:0]         cmd_field_o,
	// Link events
	input  wire logic                     transmit_last_bit_i,
	input  wire logic                     receive_end_i,
	input  wire logic                     frame_start_i,
	input  wire logic [IRQF_FAULTS-1:0]   fault_i,
	input  wire logic                     card_presence_i,
	input  wire logic [IRQF_COUNTERS-1:0] counter_underflow_i,
	// Enables
	input  wire logic [6:0]               primary_enable_i,
	input  wire logic [5:0]               secondary_enable_i,
	// Flag state
	output logic [6:0]                    event_flags_primary_o,
	output logic [6:0]                    event_flags_secondary_o
);

	// Top-level flag, global request and read data state in one record
	typedef struct packed {
		logic [6:0] primary;   // Flags 6..0 of the primary register
		logic [5:0] secondary; // Flags 5..0 of the secondary register
		logic       glob_req;  // Global request, secondary bit 6
		logic [7:0] rdata;     // Registered read data
	} irqf_state_type;

	irqf_state_type state_reg;  // Current state
	irqf_state_type state_next; // Next state

	// Helper event wiring
	irqf_evt_if evt ();

	// Decoded register writes
	logic       wr_primary;   // Write hits primary address
	logic       wr_secondary; // Write hits secondary address
	logic [6:0] set_primary;  // Host set bits, primary
	logic [6:0] clr_primary;  // Host clear bits, primary
	logic [5:0] set_second;   // Host set bits, secondary
	logic [5:0] clr_second;   // Host clear bits, secondary

	// Hardware event vectors, one bit per flag
	logic [6:0] hw_primary;   // Primary events this cycle
	logic [5:0] hw_second;    // Secondary events this cycle

	// Flags after update, before the global term
	logic [6:0] primary_upd;  // Next primary flags
	logic [5:0] second_upd;   // Next secondary flags

	// Fill level comparators
	irqf_fill_level u_fill (
		.clk_i                    (clk_i),
		.reset_i                  (reset_i),
		.stored_byte_count_i      (stored_byte_count_i),
		.buffer_capacity_select_i (buffer_capacity_select_i),
		.water_level_i            (water_level_i),
		.evt                      (evt.fill)
	);

	// Command field tracker
	irqf_cmd_watch #(
		.KNOWN_CMD_MASK (KNOWN_CMD_MASK)
	) u_cmd (
		.clk_i       (clk_i),
		.reset_i     (reset_i),
		.cmd_start_i (cmd_start_i),
		.cmd_code_i  (cmd_code_i),
		.cmd_done_i  (cmd_done_i),
		.cmd_field_o (cmd_field_o),
		.evt         (evt.cmd)
	);

	// Write decode: selector bit picks set or clear
	always_comb
	begin
		wr_primary   = reg_wr_i && (reg_addr_i == IRQF_PRIMARY_OFS);
		wr_secondary = reg_wr_i && (reg_addr_i == IRQF_SECONDARY_OFS);
		set_primary  = '0;
		clr_primary  = '0;
		set_second   = '0;
		clr_second   = '0;
		if (wr_primary)
		begin
			// Only ones act; zeros fall through untouched
			if (reg_wdata_i[IRQF_SET_POS])
				set_primary = reg_wdata_i[6:0]; // RL1 RL3
			else
				clr_primary = reg_wdata_i[6:0]; // RL2 RL3
		end
		if (wr_secondary)
		begin
			// Bit 6 is the global request; it has its own logic
			if (reg_wdata_i[IRQF_SET_POS])
				set_second = reg_wdata_i[5:0]; // RL4 RL3
			else
				clr_second = reg_wdata_i[5:0]; // RL4 RL3
		end
	end

	// Gather the hardware events into flag order
	always_comb
	begin
		hw_primary = '0;
		hw_second  = '0;
		// Levels: the flag keeps the event once the level drops
		hw_primary[IRQF_UPPER_POS]  = evt.upper_fill_status; // RL5
		hw_primary[IRQF_LOWER_POS]  = evt.lower_fill_status; // RL6
		hw_primary[IRQF_CMDEND_POS] = evt.command_end_event; // RL9
		hw_primary[IRQF_TXDONE_POS] = transmit_last_bit_i;   // RL12
		// Success is not implied; faults are read separately
		hw_primary[IRQF_RXDONE_POS] = receive_end_i;         // RL13 RL14
		hw_primary[IRQF_FAULT_POS]  = |fault_i;              // RL15
		hw_primary[IRQF_FSTART_POS] = frame_start_i;         // RL16
		hw_second[IRQF_CARD_POS]    = card_presence_i;       // RL19
		hw_second[IRQF_COUNTERS-1:0] = counter_underflow_i;  // RL20
	end

	// Next state of all flags and the read path
	always_comb
	begin
		state_next = state_reg;
		// Set terms are applied after the clear, so an event wins
		primary_upd = (state_reg.primary & ~clr_primary)
			| set_primary | hw_primary; // RL23
		second_upd  = (state_reg.secondary & ~clr_second)
			| set_second | hw_second;   // RL23
		state_next.primary   = primary_upd;
		state_next.secondary = second_upd;
		// Global request tracks stored flags under their enables;
		// it drops once software has cleared every enabled flag
		state_next.glob_req = |(primary_upd & primary_enable_i)
			|| |(second_upd & secondary_enable_i); // RL17 RL18
		// Read data: selector position always reads zero
		if (reg_rd_i)
		begin
			if (reg_addr_i == IRQF_PRIMARY_OFS)
				state_next.rdata = {1'b0, state_reg.primary}; // RL22
			else if (reg_addr_i == IRQF_SECONDARY_OFS)
				state_next.rdata = {1'b0, state_reg.glob_req,
					state_reg.secondary}; // RL22
			else
				state_next.rdata = IRQF_RDATA_RST;
		end
	end

	// State register
	always_ff @(posedge clk_i or posedge reset_i)
	begin
		if (reset_i)
		begin
			state_reg.primary   <= IRQF_PRIMARY_RST; // RL21
			state_reg.secondary <= IRQF_SECONDARY_RST;
			state_reg.glob_req  <= 1'b0;
			state_reg.rdata     <= IRQF_RDATA_RST;
		end
		else
			state_reg <= state_next;
	end

	// Outputs straight from the state register
	assign reg_rdata_o             = state_reg.rdata;
	assign event_flags_primary_o   = state_reg.primary;
	assign event_flags_secondary_o = {state_reg.glob_req,
		state_reg.secondary};

endmodule

// File: tb/irqf_props.sv
`timescale 1ns/1ps
// Checker for the event flag registers, top ports only
module irqf_props
	import irqf_pkg::*;
#(
	parameter logic [15:0] KNOWN_CMD_MASK = 16'h00ff // Legal codes
)
(
	// Clock and reset
	input wire logic                     clk_i,
	input wire logic                     reset_i,
	// Register port
	input wire logic [7:0]               reg_addr_i,
	input wire logic                     reg_wr_i,
	input wire logic                     reg_rd_i,
	input wire logic [7:0]               reg_wdata_i,
	input wire logic [7:0]               reg_rdata_o,
	// Buffer, command and events
	input wire logic [9:0]               stored_byte_count_i,
	input wire logic                     buffer_capacity_select_i,
	input wire logic [8:0]               water_level_i,
	input wire logic                     cmd_start_i,
	input wire logic [IRQF_CMD_W-1:0]    cmd_code_i,
	input wire logic [IRQF_CMD_W-1:0]    cmd_field_o,
	input wire logic                     transmit_last_bit_i,
	input wire logic [IRQF_COUNTERS-1:0] counter_underflow_i,
	// Enables and flags
	input wire logic [6:0]               primary_enable_i,
	input wire logic [5:0]               secondary_enable_i,
	input wire logic [6:0]               event_flags_primary_o,
	input wire logic [6:0]               event_flags_secondary_o
);
	logic [9:0] low_lvl; // Threshold as the comparator sees it
	logic       wr_p;    // Write to primary
	logic       wr_s;    // Write to secondary

	// Small buffer ignores the top threshold bit
	assign low_lvl = buffer_capacity_select_i ?
		{2'h0, water_level_i[7:0]} : {1'h0, water_level_i};
	assign wr_p = reg_wr_i && reg_addr_i == IRQF_PRIMARY_OFS;
	assign wr_s = reg_wr_i && reg_addr_i == IRQF_SECONDARY_OFS;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);

	// Unknown start: field back to idle, then command end flag
	sequence s_bad;
		cmd_start_i && !KNOWN_CMD_MASK[cmd_code_i];
	endsequence
	sequence s_idle_flag;
		cmd_field_o == IRQF_CMD_IDLE ##1 event_flags_primary_o[4];
	endsequence

	property p_set;
		wr_p && reg_wdata_i[7] |=> (event_flags_primary_o &
			$past(reg_wdata_i[6:0])) == $past(reg_wdata_i[6:0]);
	endproperty
	property p_clr;
		wr_p && !reg_wdata_i[7] && reg_wdata_i[3] && !transmit_last_bit_i
			|=> !event_flags_primary_o[3];
	endproperty
	// Without a primary clear write no primary flag may drop
	property p_keep;
		!(wr_p && !reg_wdata_i[7]) |=> (event_flags_primary_o &
			$past(event_flags_primary_o)) == $past(event_flags_primary_o);
	endproperty
	property p_sec;
		wr_s && reg_wdata_i[7] |=> (event_flags_secondary_o[5:0] &
			$past(reg_wdata_i[5:0])) == $past(reg_wdata_i[5:0]);
	endproperty
	property p_ctr;
		|counter_underflow_i |=> (event_flags_secondary_o[4:0] &
			$past(counter_underflow_i)) == $past(counter_underflow_i);
	endproperty
	property p_glob;
		1'b1 |-> event_flags_secondary_o[6] == |{event_flags_primary_o &
			$past(primary_enable_i),
			event_flags_secondary_o[5:0] & $past(secondary_enable_i)};
	endproperty
	property p_rd;
		reg_rd_i && reg_addr_i == IRQF_PRIMARY_OFS
			|=> reg_rdata_o == {1'b0, $past(event_flags_primary_o)};
	endproperty
	property p_bad;
		s_bad |=> s_idle_flag;
	endproperty
	property p_low;
		(stored_byte_count_i <= low_lvl)[*2] |=> event_flags_primary_o[5];
	endproperty

	a_set: assert property (p_set) else $error("set write lost");
	a_clr: assert property (p_clr) else $error("clear failed");
	a_keep: assert property (p_keep) else $error("flag dropped");
	a_sec: assert property (p_sec) else $error("second set lost");
	a_ctr: assert property (p_ctr) else $error("underflow lost");
	a_glob: assert property (p_glob) else $error("global wrong");
	a_rd: assert property (p_rd) else $error("read data wrong");
	a_bad: assert property (p_bad) else $error("unknown cmd");
	a_low: assert property (p_low) else $error("low fill lost");
endmodule

bind irqf_top irqf_props #(.KNOWN_CMD_MASK(KNOWN_CMD_MASK)) irqf_props_i (
	.clk_i, .reset_i, .reg_addr_i, .reg_wr_i, .reg_rd_i, .reg_wdata_i,
	.reg_rdata_o, .stored_byte_count_i, .buffer_capacity_select_i,
	.water_level_i, .cmd_start_i, .cmd_code_i, .cmd_field_o,
	.transmit_last_bit_i, .counter_underflow_i, .primary_enable_i,
	.secondary_enable_i, .event_flags_primary_o, .event_flags_secondary_o);

// File: tb/tb_top.sv
`timescale 1ns/1ps
// Self-checking bench for the event flag registers
module tb_top;
	import irqf_pkg::*;
	// Design ports
	logic       clk_i, reset_i, reg_wr_i, reg_rd_i, cmd_start_i, cmd_done_i;
	logic       buffer_capacity_select_i, card_presence_i;
	logic       transmit_last_bit_i, receive_end_i, frame_start_i;
	logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
	logic [9:0] stored_byte_count_i;
	logic [8:0] water_level_i;
	logic [3:0] cmd_code_i, cmd_field_o;
	logic [4:0] fault_i, counter_underflow_i;
	logic [6:0] primary_enable_i, event_flags_primary_o;
	logic [6:0] event_flags_secondary_o;
	logic [5:0] secondary_enable_i;
	// Bench state
	int         n_fail, tests_run;
	integer     seed;
	logic [6:0] p_mdl; // Expected primary flags
	logic [5:0] s_mdl; // Expected secondary flags

	irqf_top irqf_top_i (.clk_i, .reset_i, .reg_addr_i, .reg_wr_i, .reg_rd_i,
		.reg_wdata_i, .reg_rdata_o, .stored_byte_count_i,
		.buffer_capacity_select_i, .water_level_i, .cmd_start_i, .cmd_code_i,
		.cmd_done_i, .cmd_field_o, .transmit_last_bit_i, .receive_end_i,
		.frame_start_i, .fault_i, .card_presence_i, .counter_underflow_i,
		.primary_enable_i, .secondary_enable_i, .event_flags_primary_o,
		.event_flags_secondary_o);

	// Clock, 100 ns period
	initial
	begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	// Global request from flags and held enables
	function automatic logic glb(logic [6:0] p, logic [5:0] s);
		return |{p & primary_enable_i, s & secondary_enable_i};
	endfunction
	// Flags {secondary 5..0, primary 6..0} for event k
	function automatic logic [12:0] ev_exp(int k);
		case (k)
			0: return 13'h0008;
			1: return 13'h0004;
			2: return 13'h0001;
			3, 4, 5, 6, 7: return 13'h0002;
			8: return 13'h1000;
			default: return 13'h0080 << (k - 9);
		endcase
	endfunction
	// Fill cases {count, capacity select, threshold}
	function automatic logic [19:0] fcase(int j);
		case (j)
			0: return {10'h00b, 1'h1, 9'h00a};
			1: return {10'h00a, 1'h1, 9'h00a};
			2: return {10'h1f5, 1'h0, 9'h00a};
			3: return {10'h1f6, 1'h0, 9'h00a};
			4: return {10'h0f5, 1'h1, 9'h00a};
			default: return {10'h12c, 1'h0, 9'h12c};
		endcase
	endfunction
	// Expected {upper, lower} fill status
	function automatic logic [1:0] fexp(logic [19:0] f);
		logic [10:0] cap;
		logic [10:0] wl;
		cap = f[9] ? 11'h0ff : 11'h200;
		wl = f[9] ? {3'h0, f[7:0]} : {2'h0, f[8:0]};
		return {cap - {1'h0, f[19:10]} <= wl, {1'h0, f[19:10]} <= wl};
	endfunction

	task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic chkflags();
		chk("primary", {1'b0, p_mdl}, {1'b0, event_flags_primary_o});
		chk("secondary", {1'b0, glb(p_mdl, s_mdl), s_mdl},
			{1'b0, event_flags_secondary_o});
	endtask
	task automatic idle(int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask
	// One-cycle strobes, each taken at the following edge
	task automatic wr(logic [7:0] a, logic [7:0] d);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_i);
		reg_wr_i <= 1'b0;
		#1;
	endtask
	task automatic rd(logic [7:0] a, logic [7:0] exp);
		@(posedge clk_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_i);
		reg_rd_i <= 1'b0;
		#1;
		chk("read data", exp, reg_rdata_o);
	endtask
	task automatic pulse(logic [13:0] v);
		@(posedge clk_i);
		{counter_underflow_i, card_presence_i, fault_i, frame_start_i,
			receive_end_i, transmit_last_bit_i} <= v;
		@(posedge clk_i);
		{counter_underflow_i, card_presence_i, fault_i, frame_start_i,
			receive_end_i, transmit_last_bit_i} <= 14'h0000;
		#1;
	endtask
	task automatic cmd(logic st, logic [3:0] code, logic done);
		@(posedge clk_i);
		cmd_start_i <= st;
		cmd_code_i <= code;
		cmd_done_i <= done;
		@(posedge clk_i);
		cmd_start_i <= 1'b0;
		cmd_done_i <= 1'b0;
		#1;
	endtask
	task automatic close_out();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Main sequence
	initial
	begin
		logic [7:0] a;
		logic [7:0] d;
		seed = 32'hee27;
		n_fail = 0;
		tests_run = 0;
		reset_i = 1'b1;
		{reg_wr_i, reg_rd_i, cmd_start_i, cmd_done_i} = 4'h0;
		{reg_addr_i, reg_wdata_i, cmd_code_i} = 20'h00000;
		{counter_underflow_i, card_presence_i, fault_i, frame_start_i,
			receive_end_i, transmit_last_bit_i} = 14'h0000;
		// Neutral fill: neither alert
		{stored_byte_count_i, buffer_capacity_select_i, water_level_i} =
			{10'h064, 1'h1, 9'h000};
		primary_enable_i = 7'($random(seed));
		secondary_enable_i = 6'($random(seed));
		repeat (20) @(posedge clk_i);
		reset_i <= 1'b0;
		#1;
		{p_mdl, s_mdl} = 13'h0000;
		chkflags();
		rd(IRQF_PRIMARY_OFS, 8'h00);
		$display("test reset done");
		// Set/clear writes, unmapped address among them
		for (int i = 0; i < 40; i++)
		begin
			a = i < 2 ? 8'h06 : 8'h05 + 8'($unsigned($random(seed)) % 3);
			d = i == 0 ? 8'hff : i == 1 ? 8'h7f : 8'($random(seed));
			wr(a, d);
			if (a == 8'h06)
				p_mdl = d[7] ? p_mdl | d[6:0] : p_mdl & ~d[6:0];
			if (a == 8'h07)
				s_mdl = d[7] ? s_mdl | d[5:0] : s_mdl & ~d[5:0];
			chkflags();
			rd(a, a == 8'h06 ? {1'b0, p_mdl} : a == 8'h07 ?
				{1'b0, glb(p_mdl, s_mdl), s_mdl} : 8'h00);
		end
		$display("test writes done");
		wr(8'h06, 8'h7f);
		wr(8'h07, 8'h3f);
		// Each event source alone
		for (int k = 0; k < 14; k++)
		begin
			pulse(14'h0001 << k);
			{s_mdl, p_mdl} = ev_exp(k);
			chkflags();
			wr(8'h06, 8'h7f);
			wr(8'h07, 8'h3f);
		end
		// Event and clear in the same cycle: event wins
		@(posedge clk_i);
		{reg_addr_i, reg_wdata_i, reg_wr_i} <= {16'h073f, 1'b1};
		counter_underflow_i <= 5'h04;
		@(posedge clk_i);
		{reg_wr_i, counter_underflow_i} <= 6'h00;
		#1;
		{s_mdl, p_mdl} = 13'h0200;
		chkflags();
		wr(8'h07, 8'h3f);
		s_mdl = 6'h00;
		$display("test events done");
		// Fill alerts at their boundaries
		for (int j = 0; j < 6; j++)
		begin
			@(posedge clk_i);
			{stored_byte_count_i, buffer_capacity_select_i, water_level_i} <=
				fcase(j);
			idle(4);
			wr(8'h06, 8'h60);
			idle(4);
			p_mdl = {fexp(fcase(j)), 5'h00};
			chkflags();
		end
		@(posedge clk_i);
		{stored_byte_count_i, buffer_capacity_select_i, water_level_i} <=
			{10'h064, 1'h1, 9'h000};
		idle(4);
		chkflags();
		wr(8'h06, 8'h60);
		p_mdl = 7'h00;
		chkflags();
		$display("test fill done");
		// Command end cases
		cmd(1'b1, 4'h3, 1'b0);
		chk("field", 8'h03, {4'h0, cmd_field_o});
		cmd(1'b0, 4'h0, 1'b1);
		idle(1);
		chk("field", 8'h00, {4'h0, cmd_field_o});
		p_mdl = 7'h10;
		chkflags();
		wr(8'h06, 8'h10);
		// Stop a running command by hand: no flag may follow
		cmd(1'b1, 4'h2, 1'b0);
		chk("field", 8'h02, {4'h0, cmd_field_o});
		cmd(1'b1, IRQF_CMD_IDLE, 1'b0);
		chk("field", 8'h00, {4'h0, cmd_field_o});
		idle(2);
		p_mdl = 7'h00;
		chkflags();
		// Unknown code while busy must drop the field to idle
		cmd(1'b1, 4'h5, 1'b0);
		chk("field", 8'h05, {4'h0, cmd_field_o});
		cmd(1'b1, 4'h9, 1'b0);
		chk("field", 8'h00, {4'h0, cmd_field_o});
		idle(1);
		p_mdl = 7'h10;
		chkflags();
		$display("test command done");
		close_out();
	end

	// Watchdog, far beyond the expected run length
	initial
	begin
		repeat (20000) @(posedge clk_i);
		n_fail++;
		close_out();
	end
endmodule
